//--- design/pack_cfg_device.sv
`timescale 1ns/100ps
// How it works
// - Charge overcurrent auto-off unless disabled
// - Charge overcurrent always flags, powers sensor
// - Threshold field selects 0.10 to 0.16V
// - Short circuit delay 190us or 10ms
// - Charge delay divided by 32 when set
// - Discharge delay divided by 64 when set
// - Charge timeout 80 to 640ms by code
// - Sensor powered 5ms per 640ms unless disabled
// - Regulator disable bit turns regulator off
// - Force bit holds sensor supply on
// - External overtemp auto-off disable, still flagged
// - Internal overtemp auto-off disable, still flagged
// - Force-reset bit clears all registers except the two user flags
// - Wake pin disable blocks pin wake-up
// - Polarity bit picks wake edge
// - Feature register writable only when unlocked
// - Charge register writable only when unlocked
// - Discharge register writable only when unlocked
// - Two user flags survive regulator off
// - Charge overcurrent auto-off clears charge switch bit
module pack_cfg_device
	import pack_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	pack_cfg_if.dev bus,
	input wire logic chg_oc_detect,
	input wire logic short_detect,
	input wire logic ext_overtemp,
	input wire logic int_overtemp,
	input wire logic wake_pin,
	input wire logic asleep,
	output logic [1:0] chg_oc_threshold,
	output logic chg_oc_timeout,
	output logic short_timeout,
	output logic [7:0] dis_delay_scale,
	output logic fet_off,
	output logic charge_switch_on,
	output logic sensor_supply_out,
	output logic regulator_disable,
	output logic wake_event
);
	// ==========================================================
	// Register file
	logic [7:0] discharge_config_r;
	logic [7:0] charge_timing_config_r;
	logic [7:0] feature_config_r;
	logic [7:0] write_unlock_r;
	logic [1:0] user_flags_r;
	logic chg_overcurrent_flag_r;
	logic ext_overtemp_flag_r;
	logic int_overtemp_flag_r;
	logic charge_switch_r;
	logic soft_por_r;
	logic chg_trip;
	logic short_trip;
	logic wr_charge;
	logic wr_feature;
	logic wr_discharge;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
		hit = bus.wr_en && (a == ref_a);
	endfunction

	always_comb begin
		wr_discharge = 1'b0;
		wr_charge = 1'b0;
		wr_feature = 1'b0;
		if (hit(bus.addr, DISCHARGE_CONFIG_ADDR))
			wr_discharge = write_unlock_r[DISCHARGE_WRITE_ENABLE_BIT];
		else if (hit(bus.addr, CHARGE_TIMING_CONFIG_ADDR))
			wr_charge = write_unlock_r[CHARGE_WRITE_ENABLE_BIT];
		else if (hit(bus.addr, FEATURE_CONFIG_ADDR))
			wr_feature = write_unlock_r[FEATURE_WRITE_ENABLE_BIT];
	end

	// Force-reset pulse lasts one cycle and wipes the bank next edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			soft_por_r <= 1'b0;
		end else begin
			soft_por_r <= wr_feature && bus.wdata[FORCE_RESET_BIT];
		end
	end

	// Locked writes simply fall through unchanged
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			discharge_config_r <= REG_RESET;
			charge_timing_config_r <= REG_RESET;
			feature_config_r <= REG_RESET;
			write_unlock_r <= REG_RESET;
		end else if (soft_por_r) begin
			discharge_config_r <= REG_RESET;
			charge_timing_config_r <= REG_RESET;
			feature_config_r <= REG_RESET;
			write_unlock_r <= REG_RESET;
		end else begin
			if (wr_discharge)
				discharge_config_r <= bus.wdata;
			if (wr_charge)
				charge_timing_config_r <= bus.wdata;
			if (wr_feature)
				feature_config_r <= bus.wdata & ~(8'h01 << FORCE_RESET_BIT);
			if (hit(bus.addr, WRITE_UNLOCK_ADDR))
				write_unlock_r <= bus.wdata & WRITE_UNLOCK_MASK;
		end
	end

	// User flags sit in the battery-backed well: only rstn or a write to 08H clears them,
	// the regulator-off state and force reset leave them alone.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			user_flags_r <= 2'b00;
		end else if (hit(bus.addr, WRITE_UNLOCK_ADDR)) begin
			user_flags_r <= {bus.wdata[USER_FLAG_B_BIT],
				bus.wdata[USER_FLAG_A_BIT]};
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bus.rdata <= 8'h00;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rvalid <= bus.rd_en;
			if (bus.rd_en) begin
				if (bus.addr == DISCHARGE_CONFIG_ADDR)
					bus.rdata <= discharge_config_r;
				else if (bus.addr == CHARGE_TIMING_CONFIG_ADDR)
					bus.rdata <= charge_timing_config_r;
				else if (bus.addr == FEATURE_CONFIG_ADDR)
					bus.rdata <= feature_config_r;
				else if (bus.addr == WRITE_UNLOCK_ADDR)
					bus.rdata <= {write_unlock_r[7:5], user_flags_r, 3'b000};
				else if (bus.addr == STATUS_ADDR)
					bus.rdata <= {4'h0, charge_switch_r, int_overtemp_flag_r,
						ext_overtemp_flag_r, chg_overcurrent_flag_r};
				else
					bus.rdata <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Microsecond tick and delay timers
	logic [TICK_W-1:0] tick_cnt_r;
	logic tick;
	logic [TIMER_W-1:0] chg_cnt_r;
	logic [TIMER_W-1:0] short_cnt_r;
	logic [TIMER_W-1:0] scan_cnt_r;
	logic [TIMER_W-1:0] chg_limit;
	logic [TIMER_W-1:0] short_limit;

	assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
	end

	// Timeout doubles per code; div32 turns 80ms into 2.5ms
	always_comb begin
		chg_limit = TIMER_W'(CHG_OC_BASE_TICKS)
			<< charge_timing_config_r[CHG_OC_TIMEOUT_HI_BIT:
				CHG_OC_TIMEOUT_LO_BIT];
		if (charge_timing_config_r[CHG_DELAY_DIV32_BIT])
			chg_limit = chg_limit / TIMER_W'(CHG_DIV);
		short_limit = charge_timing_config_r[SHORT_LONG_DELAY_BIT] ?
			TIMER_W'(SHORT_LONG_TICKS) : TIMER_W'(SHORT_DELAY_TICKS);
	end

	// Discharge timing lives elsewhere; only the divisor leaves here
	assign dis_delay_scale = charge_timing_config_r[DIS_DELAY_DIV64_BIT] ?
		8'(DIS_DIV) : 8'h01;
	assign chg_oc_threshold = charge_timing_config_r[
		CHG_OC_THRESHOLD_HI_BIT:CHG_OC_THRESHOLD_LO_BIT];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			chg_cnt_r <= '0;
		end else if (!chg_oc_detect) begin
			chg_cnt_r <= '0;
		end else if (tick && chg_cnt_r < chg_limit) begin
			chg_cnt_r <= chg_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			short_cnt_r <= '0;
		end else if (!short_detect) begin
			short_cnt_r <= '0;
		end else if (tick && short_cnt_r < short_limit) begin
			short_cnt_r <= short_cnt_r + 1'b1;
		end
	end

	assign chg_trip = chg_oc_detect && (chg_cnt_r >= chg_limit);
	assign short_trip = short_detect && (short_cnt_r >= short_limit);
	assign chg_oc_timeout = chg_trip;
	assign short_timeout = short_trip;

	// ==========================================================
	// Flags and FET control; force reset wins over events
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			chg_overcurrent_flag_r <= 1'b0;
			ext_overtemp_flag_r <= 1'b0;
			int_overtemp_flag_r <= 1'b0;
		end else if (soft_por_r) begin
			chg_overcurrent_flag_r <= 1'b0;
			ext_overtemp_flag_r <= 1'b0;
			int_overtemp_flag_r <= 1'b0;
		end else begin
			if (chg_trip)
				chg_overcurrent_flag_r <= 1'b1;
			if (ext_overtemp)
				ext_overtemp_flag_r <= 1'b1;
			if (int_overtemp)
				int_overtemp_flag_r <= 1'b1;
		end
	end

	logic auto_off;
	always_comb begin
		auto_off = 1'b0;
		if (chg_trip && !charge_timing_config_r[CHG_OC_AUTO_OFF_DISABLE_BIT])
			auto_off = 1'b1;
		if (ext_overtemp && !feature_config_r[EXT_THERMAL_OFF_DISABLE_BIT])
			auto_off = 1'b1;
		if (int_overtemp && !feature_config_r[INT_THERMAL_OFF_DISABLE_BIT])
			auto_off = 1'b1;
	end

	// Charge switch set by host at status address bit3
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			charge_switch_r <= 1'b0;
			fet_off <= 1'b0;
		end else if (soft_por_r) begin
			charge_switch_r <= 1'b0;
			fet_off <= 1'b0;
		end else begin
			fet_off <= auto_off;
			if (auto_off)
				charge_switch_r <= 1'b0;
			else if (hit(bus.addr, STATUS_ADDR))
				charge_switch_r <= bus.wdata[3];
		end
	end
	assign charge_switch_on = charge_switch_r;

	// ==========================================================
	// Sensor supply scan
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			scan_cnt_r <= '0;
		else if (tick)
			scan_cnt_r <= (scan_cnt_r == TIMER_W'(SCAN_PERIOD_TICKS - 1)) ?
				'0 : scan_cnt_r + 1'b1;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sensor_supply_out <= 1'b0;
			regulator_disable <= 1'b0;
		end else begin
			sensor_supply_out <= feature_config_r[SENSOR_SUPPLY_FORCE_BIT]
				|| chg_overcurrent_flag_r
				|| (!feature_config_r[TEMP_SCAN_DISABLE_BIT]
				&& scan_cnt_r < TIMER_W'(SCAN_ON_TICKS));
			regulator_disable <= feature_config_r[REGULATOR_DISABLE_BIT];
		end
	end

	// ==========================================================
	// Wake detection; pin taken as synchronous
	logic wake_prev_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wake_prev_r <= 1'b0;
			wake_event <= 1'b0;
		end else begin
			wake_prev_r <= wake_pin;
			wake_event <= asleep && !feature_config_r[WAKE_PIN_DISABLE_BIT]
				&& (feature_config_r[WAKE_POLARITY_BIT] ?
				(wake_pin && !wake_prev_r) : (!wake_pin && wake_prev_r));
		end
	end
endmodule // pack_cfg_device

//--- design/pack_cfg_pkg.sv
package pack_cfg_pkg;
	// ==========================================================
	// Register map
	localparam logic [3:0] DISCHARGE_CONFIG_ADDR = 4'h5;
	localparam logic [3:0] CHARGE_TIMING_CONFIG_ADDR = 4'h6;
	localparam logic [3:0] FEATURE_CONFIG_ADDR = 4'h7;
	localparam logic [3:0] WRITE_UNLOCK_ADDR = 4'h8;
	localparam logic [3:0] STATUS_ADDR = 4'h9;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ==========================================================
	// Bit positions
	localparam int CHG_OC_AUTO_OFF_DISABLE_BIT = 7;
	localparam int CHG_OC_THRESHOLD_HI_BIT = 6;
	localparam int CHG_OC_THRESHOLD_LO_BIT = 5;
	localparam int SHORT_LONG_DELAY_BIT = 4;
	localparam int CHG_DELAY_DIV32_BIT = 3;
	localparam int DIS_DELAY_DIV64_BIT = 2;
	localparam int CHG_OC_TIMEOUT_HI_BIT = 1;
	localparam int CHG_OC_TIMEOUT_LO_BIT = 0;
	localparam int TEMP_SCAN_DISABLE_BIT = 7;
	localparam int REGULATOR_DISABLE_BIT = 6;
	localparam int SENSOR_SUPPLY_FORCE_BIT = 5;
	localparam int EXT_THERMAL_OFF_DISABLE_BIT = 4;
	localparam int INT_THERMAL_OFF_DISABLE_BIT = 3;
	localparam int FORCE_RESET_BIT = 2;
	localparam int WAKE_PIN_DISABLE_BIT = 1;
	localparam int WAKE_POLARITY_BIT = 0;
	localparam int FEATURE_WRITE_ENABLE_BIT = 7;
	localparam int CHARGE_WRITE_ENABLE_BIT = 6;
	localparam int DISCHARGE_WRITE_ENABLE_BIT = 5;
	localparam int USER_FLAG_B_BIT = 4;
	localparam int USER_FLAG_A_BIT = 3;
	localparam logic [7:0] WRITE_UNLOCK_MASK = 8'hF8;
	// Status: bit0 charge oc, bit1 ext ot, bit2 int ot, bit3 charge on
	// ==========================================================
	// Timing, 100 MHz clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int SHORT_DELAY_US = 190;
	localparam int SHORT_LONG_DELAY_MS = 10;
	localparam int CHG_OC_BASE_MS = 80;
	localparam int SCAN_ON_MS = 5;
	localparam int SCAN_PERIOD_MS = 640;
	localparam int CHG_DIV = 32;
	localparam int DIS_DIV = 64;
	localparam int SHORT_DELAY_TICKS = SHORT_DELAY_US / TICK_US;
	localparam int SHORT_LONG_TICKS = SHORT_LONG_DELAY_MS * 1000 / TICK_US;
	localparam int CHG_OC_BASE_TICKS = CHG_OC_BASE_MS * 1000 / TICK_US;
	localparam int SCAN_ON_TICKS = SCAN_ON_MS * 1000 / TICK_US;
	localparam int SCAN_PERIOD_TICKS = SCAN_PERIOD_MS * 1000 / TICK_US;
	localparam int TIMER_W = 20;
	localparam int TICK_W = 7;

	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_WRITE,
		HOST_READ
	} host_state_e;
endpackage

//--- design/pack_cfg_if.sv
`timescale 1ns/100ps
interface pack_cfg_if;
	logic wr_en;
	logic rd_en;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;

	modport dev (
		input wr_en,
		input rd_en,
		input addr,
		input wdata,
		output rdata,
		output rvalid
	);
	modport host (
		output wr_en,
		output rd_en,
		output addr,
		output wdata,
		input rdata,
		input rvalid
	);
endinterface

//--- design/pack_cfg_host.sv
`timescale 1ns/100ps
module pack_cfg_host
	import pack_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [3:0] req_addr,
	input wire logic [7:0] req_data,
	output logic req_ready,
	output logic [7:0] resp_data,
	output logic resp_valid,
	pack_cfg_if.host bus
);
	// ==========================================================
	// Command sequencer
	// Writes to locked registers are sent as asked; the device drops them.
	// Software unlocks 08H first.
	// A wake_pin edge is the wake path; this bus only sets wake_pin_disable and the wake polarity bit.
	host_state_e state_r;
	logic [3:0] addr_r;
	logic [7:0] data_r;

	assign req_ready = (state_r == HOST_IDLE);
	assign bus.wr_en = (state_r == HOST_WRITE);
	assign bus.rd_en = (state_r == HOST_READ);
	assign bus.addr = addr_r;
	assign bus.wdata = data_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r <= HOST_IDLE;
			addr_r <= 4'h0;
			data_r <= 8'h00;
		end else begin
			case (state_r)
				HOST_IDLE: begin
					if (req_valid) begin
						addr_r <= req_addr;
						data_r <= req_data;
						state_r <= req_write ? HOST_WRITE : HOST_READ;
					end
				end
				default: state_r <= HOST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			resp_data <= 8'h00;
			resp_valid <= 1'b0;
		end else begin
			resp_valid <= bus.rvalid;
			if (bus.rvalid)
				resp_data <= bus.rdata;
		end
	end
endmodule // pack_cfg_host

//--- testbench/pack_cfg_properties.sv
`timescale 1ns/100ps
module pack_cfg_properties
	import pack_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	// ======
	// Shadow of the lockable registers, kept from bus traffic only
	logic [7:0] dis_r;
	logic [7:0] chg_r;
	logic [7:0] feat_r;
	logic [7:0] unlock_r;
	logic clr;
	assign clr = wr_en && addr == FEATURE_CONFIG_ADDR && wdata[2] && unlock_r[7];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dis_r <= 8'h00;
			chg_r <= 8'h00;
			feat_r <= 8'h00;
			unlock_r <= 8'h00;
		end else if (clr) begin
			dis_r <= 8'h00;
			chg_r <= 8'h00;
			feat_r <= 8'h00;
			// User flags live on the battery supply
			unlock_r <= unlock_r & 8'h18;
		end else if (wr_en) begin
			if (addr == DISCHARGE_CONFIG_ADDR && unlock_r[5])
				dis_r <= wdata;
			if (addr == CHARGE_TIMING_CONFIG_ADDR && unlock_r[6])
				chg_r <= wdata;
			if (addr == FEATURE_CONFIG_ADDR && unlock_r[7])
				feat_r <= wdata & 8'hFB;
			if (addr == WRITE_UNLOCK_ADDR)
				unlock_r <= wdata & WRITE_UNLOCK_MASK;
		end
	end

	// ======
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	property p_answer; rd_en |=> rvalid; endproperty
	a_answer: assert property (p_answer)
		else $error("read not answered next cycle");
	property p_quiet; !rd_en |=> !rvalid; endproperty
	a_quiet: assert property (p_quiet)
		else $error("answer without a read");
	property p_once; rvalid |=> !rvalid; endproperty
	a_once: assert property (p_once)
		else $error("answer longer than one cycle");
	property p_unmapped; rd_en && addr > STATUS_ADDR |=> rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_dis;
		rd_en && addr == DISCHARGE_CONFIG_ADDR |=> rdata == $past(dis_r);
	endproperty
	a_dis: assert property (p_dis)
		else $error("discharge config content wrong");
	property p_chg;
		rd_en && addr == CHARGE_TIMING_CONFIG_ADDR |=> rdata == $past(chg_r);
	endproperty
	a_chg: assert property (p_chg)
		else $error("charge config content wrong");
	property p_feat;
		rd_en && addr == FEATURE_CONFIG_ADDR |=> rdata == $past(feat_r);
	endproperty
	a_feat: assert property (p_feat)
		else $error("feature config content wrong");
	property p_unlock;
		rd_en && addr == WRITE_UNLOCK_ADDR |=> rdata == $past(unlock_r);
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("unlock register content wrong");
endmodule // pack_cfg_properties

//--- testbench/pack_cfg_test.sv
`timescale 1ns/100ps
module pack_cfg_test
	import pack_cfg_pkg::*;
;
	logic clock = 0;
	logic rstn = 0;
	logic req_valid = 0;
	logic req_write = 0;
	logic [3:0] req_addr = 4'h0;
	logic [7:0] req_data = 8'h00;
	logic shrt = 0, ext_ot = 0, int_ot = 0, wake = 0, asleep = 0;
	logic chg_oc = 0;
	logic req_ready, resp_valid, chg_to, short_to, fet_off, chg_sw;
	logic sensor, reg_dis, wake_ev;
	logic [1:0] thr;
	logic [7:0] resp_data, dis_scale, d;
	logic [7:0] expq[$];
	int n_mismatch = 0, n_tests = 0, cyc = 0, n_wake = 0, base;

	pack_cfg_if bus ();
	pack_cfg_host pack_cfg_host_inst (.clock(clock), .rstn(rstn),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_data(req_data), .req_ready(req_ready), .resp_data(resp_data),
		.resp_valid(resp_valid), .bus(bus));
	pack_cfg_device pack_cfg_device_inst (.clock(clock), .rstn(rstn),
		.bus(bus), .chg_oc_detect(chg_oc), .short_detect(shrt),
		.ext_overtemp(ext_ot), .int_overtemp(int_ot), .wake_pin(wake),
		.asleep(asleep), .chg_oc_threshold(thr), .chg_oc_timeout(chg_to),
		.short_timeout(short_to), .dis_delay_scale(dis_scale),
		.fet_off(fet_off), .charge_switch_on(chg_sw),
		.sensor_supply_out(sensor), .regulator_disable(reg_dis),
		.wake_event(wake_ev));
	pack_cfg_properties pack_cfg_properties_inst (.clock(clock),
		.rstn(rstn), .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
		.wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));

	always #5 clock = ~clock;

	// ======
	// Shared tasks
	task check(input string what, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task conclude();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task req(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		#1;
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_data = v;
		while (req_ready !== 1'b1) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1;
		req_valid = 0;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		req(1'b1, a, v);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		expq.push_back(e);
		req(1'b0, a, 8'h00);
	endtask
	task settle();
		repeat (4) @(posedge clock);
		#1;
	endtask

	// ======
	// Response monitor and hang guard
	always @(posedge clock) begin
		cyc++;
		if (wake_ev === 1'b1)
			n_wake++;
		if (resp_valid === 1'b1)
			check("read data", expq.size() ? expq.pop_front() : 8'hXX, resp_data);
		if (cyc == 90000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ======
	// Main sequence
	initial begin
		void'($urandom(40070));
		repeat (2) @(posedge clock);
		#1;
		rstn = 1;
		for (int a = 5; a < 12; a++) rd(4'(a), 8'h00);
		check("sensor supply", 1, sensor);
		$display("reset test done");
		for (int a = 5; a < 8; a++) wr(4'(a), 8'hFB);
		for (int a = 5; a < 8; a++) rd(4'(a), 8'h00);
		$display("locked write test done");
		d = 8'($urandom);
		wr(4'h8, 8'hE0 | (d & 8'h1F));
		rd(4'h8, 8'hE0 | (d & 8'h18));
		d = 8'($urandom);
		wr(4'h5, d);
		rd(4'h5, d);
		// Short delay kept at 190us for the timer test
		d = 8'($urandom) & 8'hEF;
		wr(4'h6, d);
		rd(4'h6, d);
		settle();
		check("threshold", d[6:5], thr);
		check("discharge scale", d[2] ? 8'h40 : 8'h01, dis_scale);
		wr(4'h7, 8'h80);
		settle();
		check("sensor supply", 0, sensor);
		wr(4'h7, 8'hE0);
		settle();
		check("sensor supply", 1, sensor);
		check("regulator off", 1, reg_dis);
		$display("config test done");
		wr(4'h9, 8'h08);
		settle();
		check("charge switch", 1, chg_sw);
		for (int i = 0; i < 4; i++) begin
			wr(4'h7, i[1] ? 8'h18 : 8'h00);
			ext_ot = !i[0];
			int_ot = i[0];
			settle();
			check("fet off", !i[1], fet_off);
			ext_ot = 0;
			int_ot = 0;
			settle();
		end
		check("charge switch", 0, chg_sw);
		rd(4'h9, 8'h06);
		$display("overtemp test done");
		shrt = 1;
		repeat (15000) @(posedge clock);
		#1;
		shrt = 0;
		@(posedge clock);
		#1;
		shrt = 1;
		repeat (15000) @(posedge clock);
		#1;
		check("short early", 0, short_to);
		repeat (5000) @(posedge clock);
		#1;
		check("short timeout", 1, short_to);
		shrt = 0;
		$display("short circuit test done");
		// Shortest charge delay is 2.5ms, beyond the run budget
		chg_oc = 1;
		repeat (2000) @(posedge clock);
		#1;
		check("charge timeout early", 0, chg_to);
		check("fet off", 0, fet_off);
		chg_oc = 0;
		settle();
		rd(4'h9, 8'h06);
		$display("charge overcurrent test done");
		asleep = 1;
		for (int i = 0; i < 3; i++) begin
			wr(4'h7, 8'(i));
			wake = !i[0];
			settle();
			base = n_wake;
			wake = i[0];
			settle();
			check("wake events", i < 2, 8'(n_wake - base));
		end
		asleep = 0;
		$display("wake test done");
		wr(4'h8, 8'h98);
		wr(4'h7, 8'h04);
		settle();
		rd(4'h8, 8'h18);
		rd(4'h6, 8'h00);
		rd(4'h9, 8'h00);
		repeat (10) @(posedge clock);
		check("pending reads", 0, 8'(expq.size()));
		$display("force reset test done");
		conclude();
	end
endmodule // pack_cfg_test
